// ---- core/fum_regs.svh ----
// constants of the flash update uart master: codes, framing, timing
// assumes a single clock at FUM_CLK_HZ; included by the core
`ifndef FUM_REGS_SVH
`define FUM_REGS_SVH

// ==========================================================
// clock and link timing
`define FUM_CLK_HZ 25000000
`define FUM_BAUD 31250
`define FUM_BIT_CYC (`FUM_CLK_HZ / `FUM_BAUD)
`define FUM_HALF_CYC (`FUM_BIT_CYC / 2)
`define FUM_LED_STEP_MS 250
`define FUM_LED_STEP_CYC ((`FUM_CLK_HZ / 1000) * `FUM_LED_STEP_MS)

// ==========================================================
// character framing
`define FUM_DATA_BITS 4'h8
`define FUM_FRAME_BITS 4'hA
`define FUM_IDLE_LVL 1'h1

// ==========================================================
// command and status codes
`define FUM_CMD_START 8'h10
`define FUM_CMD_ERASE 8'h11
`define FUM_CMD_WRITE 8'h12
`define FUM_READY_CODE 8'h55
`define FUM_PAD_BYTE 8'hFF

// ==========================================================
// block and size limits
`define FUM_LAST_INDEX 8'h25
`define FUM_LAST_BIG_INDEX 8'h1D
`define FUM_BIG_BLOCK 32'h0000_4000
`define FUM_SMALL_BLOCK 32'h0000_1000
`define FUM_MAX_DATA 32'h0000_2000
`define FUM_UNIT_LAST 8'hFF
`define FUM_SIZE_BYTES 2'h3

// ==========================================================
// indicator patterns
`define FUM_LED_OFF 4'h0
`define FUM_LED_FIRST 4'h1
`define FUM_LED_ERROR 4'h1

`endif

// ---- core/fum_pkg.sv ----
// types shared by the flash update uart master
// assumes fum_regs.svh for all numeric constants
package fum_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    FUM_IDLE,
    FUM_SEND_START,
    FUM_SEND_ERASE,
    FUM_SEND_INDEX,
    FUM_SEND_WRITE,
    FUM_SEND_SIZE,
    FUM_SEND_DATA,
    FUM_WAIT_READY,
    FUM_DONE,
    FUM_ERROR
  } fum_state_t;

  // ==========================================================
  // session setup captured at the switch press
  typedef struct packed {
    logic [7:0] block_index;
    logic [31:0] prog_size;
  } fum_cfg_t;

  // ==========================================================
  // outward status
  typedef struct packed {
    logic busy;
    logic done;
    logic error;
  } fum_status_t;

endpackage : fum_pkg

// ---- core/fum_master.sv ----
// flash update uart master: sequencer, transmitter and receiver
// assumes a slave that answers each step with the ready code, and a
// data source on the same clock that holds a byte until it is taken
// Notes on behaviour
// - link runs asynchronous at 31250 bit/s, bit time derived from clock
// - each character: one start bit, eight data bits, no parity, one stop
// - exchange starts only on a detected press of the start switch
// - after each transmission step, wait for ready code 55h before more
// - session opens with command byte 10h
// - erase is requested with command byte 11h
// - programming is requested with command byte 12h
// - exactly one erase block, index 00h to 25h, is the erase target
// - size and data follow only after the slave finished erasing
// - both ends use the same byte order for the four size bytes
// - successful completion is shown on the four indicators
// - receive overrun or framing error aborts and shows error pattern
// - block index byte follows erase command; 26h and above invalid
// - data goes in 256-byte units, last one padded with FFh
// - four size bytes follow write command; nonzero, within block size
`timescale 1ns/100ps
`include "fum_regs.svh"

module fum_master import fum_pkg::*; #(
  parameter int BIT_CYC = `FUM_BIT_CYC,
  parameter int LED_STEP_CYC = `FUM_LED_STEP_CYC,
  parameter bit BIG_ENDIAN = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // start switch, low while pressed
  input wire logic start_switch_n_in,
  // serial link
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  // session setup, sampled at the press
  input wire fum_cfg_t cfg_in,
  // programming data source
  input wire logic [7:0] data_in,
  input wire logic data_valid_in,
  output logic data_ready_out,
  // indicators and status
  output logic [3:0] indicator_out,
  output fum_status_t status_out
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] block_bytes(input logic [7:0] idx);
    block_bytes = (idx <= `FUM_LAST_BIG_INDEX) ? `FUM_BIG_BLOCK
                                               : `FUM_SMALL_BLOCK;
  endfunction : block_bytes

  function automatic logic cfg_ok(input fum_cfg_t c);
    cfg_ok = (c.block_index <= `FUM_LAST_INDEX) &&
             (c.prog_size != 32'h0) &&
             (c.prog_size <= block_bytes(c.block_index)) &&
             (c.prog_size <= `FUM_MAX_DATA);
  endfunction : cfg_ok

  // ==========================================================
  // input synchronisers: the first stage feeds only the second
  logic [2:0] rx_sync_reg, rx_sync_next;
  logic [2:0] sw_sync_reg, sw_sync_next;
  logic rx_lvl_reg, rx_lvl_next;
  logic sw_lvl_reg, sw_lvl_next;
  logic sw_press;

  always_comb begin
    rx_sync_next = {rx_sync_reg[1:0], serial_rx_in};
    sw_sync_next = {sw_sync_reg[1:0], start_switch_n_in};
    rx_lvl_next = rx_lvl_reg;
    sw_lvl_next = sw_lvl_reg;
    if (rx_sync_reg[1] == rx_sync_reg[2]) begin
      rx_lvl_next = rx_sync_reg[2];
    end
    if (sw_sync_reg[1] == sw_sync_reg[2]) begin
      sw_lvl_next = sw_sync_reg[2];
    end
  end

  assign sw_press = sw_lvl_reg && !sw_lvl_next;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_sync_reg <= 3'h7;
      sw_sync_reg <= 3'h7;
      rx_lvl_reg <= 1'h1;
      sw_lvl_reg <= 1'h1;
    end else begin
      rx_sync_reg <= rx_sync_next;
      sw_sync_reg <= sw_sync_next;
      rx_lvl_reg <= rx_lvl_next;
      sw_lvl_reg <= sw_lvl_next;
    end
  end

  // ==========================================================
  // transmitter
  logic tx_go;
  logic [7:0] tx_byte;
  logic tx_busy_reg, tx_busy_next;
  logic [9:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sh_reg, tx_sh_next;

  always_comb begin
    tx_busy_next = tx_busy_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    if (!tx_busy_reg) begin
      if (tx_go) begin
        tx_busy_next = 1'h1;
        tx_sh_next = {1'h1, tx_byte, 1'h0};
        tx_cnt_next = 10'h0;
        tx_bit_next = 4'h0;
      end
    end else if (tx_cnt_reg == 10'(BIT_CYC - 1)) begin
      tx_cnt_next = 10'h0;
      tx_sh_next = {`FUM_IDLE_LVL, tx_sh_reg[9:1]};
      tx_bit_next = tx_bit_reg + 4'h1;
      if (tx_bit_reg == `FUM_FRAME_BITS - 4'h1) begin
        tx_busy_next = 1'h0;
      end
    end else begin
      tx_cnt_next = tx_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_busy_reg <= 1'h0;
      tx_cnt_reg <= 10'h0;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
    end else begin
      tx_busy_reg <= tx_busy_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
    end
  end

  assign serial_tx_out = tx_busy_reg ? tx_sh_reg[0] : `FUM_IDLE_LVL;

  // ==========================================================
  // receiver; a held byte is cleared in the wait state and outside a session
  logic rx_act_reg, rx_act_next;
  logic [9:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic [7:0] rx_data_reg, rx_data_next;
  logic rx_full_reg, rx_full_next;
  logic rx_ovr_reg, rx_ovr_next;
  logic rx_frm_reg, rx_frm_next;
  logic rx_take;

  always_comb begin
    rx_act_next = rx_act_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_data_next = rx_data_reg;
    rx_full_next = rx_full_reg && !rx_take;
    rx_ovr_next = 1'h0;
    rx_frm_next = 1'h0;
    if (!rx_act_reg) begin
      if (rx_lvl_reg && !rx_lvl_next) begin
        rx_act_next = 1'h1;
        rx_cnt_next = 10'h0;
        rx_bit_next = 4'h0;
      end
    end else if (rx_bit_reg == 4'h0 &&
                 rx_cnt_reg == 10'(BIT_CYC / 2 - 1)) begin
      rx_cnt_next = 10'h0;
      rx_bit_next = 4'h1;
      if (rx_lvl_reg) begin
        rx_act_next = 1'h0;
      end
    end else if (rx_bit_reg != 4'h0 &&
                 rx_cnt_reg == 10'(BIT_CYC - 1)) begin
      rx_cnt_next = 10'h0;
      rx_bit_next = rx_bit_reg + 4'h1;
      if (rx_bit_reg <= `FUM_DATA_BITS) begin
        rx_sh_next = {rx_lvl_reg, rx_sh_reg[7:1]};
      end else begin
        rx_act_next = 1'h0;
        if (!rx_lvl_reg) begin
          rx_frm_next = 1'h1;
        end else begin
          rx_data_next = rx_sh_reg;
          rx_full_next = 1'h1;
          rx_ovr_next = rx_full_reg && !rx_take;
        end
      end
    end else begin
      rx_cnt_next = rx_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_act_reg <= 1'h0;
      rx_cnt_reg <= 10'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      rx_full_reg <= 1'h0;
      rx_ovr_reg <= 1'h0;
      rx_frm_reg <= 1'h0;
    end else begin
      rx_act_reg <= rx_act_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
      rx_data_reg <= rx_data_next;
      rx_full_reg <= rx_full_next;
      rx_ovr_reg <= rx_ovr_next;
      rx_frm_reg <= rx_frm_next;
    end
  end

  // ==========================================================
  // sequencer
  fum_state_t st_reg, st_next;
  fum_state_t ret_reg, ret_next;
  fum_cfg_t cfg_reg, cfg_next;
  logic [1:0] szi_reg, szi_next;
  logic [31:0] sent_reg, sent_next;
  logic [1:0] sz_sel;
  logic active;
  logic have_data;

  assign active = (st_reg != FUM_IDLE) && (st_reg != FUM_DONE) &&
                  (st_reg != FUM_ERROR);
  // the wait state and the rest states read the receiver empty
  assign rx_take = rx_full_reg && !(active && st_reg != FUM_WAIT_READY);
  assign have_data = sent_reg < cfg_reg.prog_size;
  assign sz_sel = BIG_ENDIAN ? (`FUM_SIZE_BYTES - szi_reg) : szi_reg;

  always_comb begin
    st_next = st_reg;
    ret_next = ret_reg;
    cfg_next = cfg_reg;
    szi_next = szi_reg;
    sent_next = sent_reg;
    tx_go = 1'h0;
    tx_byte = `FUM_PAD_BYTE;
    data_ready_out = 1'h0;
    case (st_reg)
      FUM_IDLE, FUM_DONE: begin
        if (sw_press) begin
          cfg_next = cfg_in;
          sent_next = 32'h0;
          szi_next = 2'h0;
          // a bad setup never reaches the link
          st_next = cfg_ok(cfg_in) ? FUM_SEND_START : FUM_ERROR;
        end
      end
      FUM_SEND_START: begin
        tx_byte = `FUM_CMD_START;
        tx_go = !tx_busy_reg;
        if (tx_go) begin
          st_next = FUM_WAIT_READY;
          ret_next = FUM_SEND_ERASE;
        end
      end
      FUM_SEND_ERASE: begin
        tx_byte = `FUM_CMD_ERASE;
        tx_go = !tx_busy_reg;
        if (tx_go) begin
          st_next = FUM_SEND_INDEX;
        end
      end
      FUM_SEND_INDEX: begin
        tx_byte = cfg_reg.block_index;
        tx_go = !tx_busy_reg;
        if (tx_go) begin
          st_next = FUM_WAIT_READY;
          ret_next = FUM_SEND_WRITE;
        end
      end
      FUM_SEND_WRITE: begin
        tx_byte = `FUM_CMD_WRITE;
        tx_go = !tx_busy_reg;
        if (tx_go) begin
          st_next = FUM_SEND_SIZE;
        end
      end
      FUM_SEND_SIZE: begin
        tx_byte = cfg_reg.prog_size[8 * sz_sel +: 8];
        tx_go = !tx_busy_reg;
        if (tx_go) begin
          szi_next = szi_reg + 2'h1;
          if (szi_reg == `FUM_SIZE_BYTES) begin
            st_next = FUM_WAIT_READY;
            ret_next = FUM_SEND_DATA;
          end
        end
      end
      FUM_SEND_DATA: begin
        tx_byte = have_data ? data_in : `FUM_PAD_BYTE;
        data_ready_out = !tx_busy_reg && have_data;
        tx_go = !tx_busy_reg && (data_valid_in || !have_data);
        if (tx_go) begin
          sent_next = sent_reg + 32'h1;
          if (sent_reg[7:0] == `FUM_UNIT_LAST) begin
            st_next = FUM_WAIT_READY;
            ret_next = (sent_next >= cfg_reg.prog_size) ? FUM_DONE
                                                       : FUM_SEND_DATA;
          end
        end
      end
      FUM_WAIT_READY: begin
        // the answer counts only once our own frame has left
        if (rx_full_reg && !tx_busy_reg &&
            rx_data_reg == `FUM_READY_CODE) begin
          st_next = ret_reg;
        end
      end
      default: begin
        st_next = FUM_ERROR;
      end
    endcase
    if (active && (rx_ovr_reg || rx_frm_reg)) begin
      st_next = FUM_ERROR;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= FUM_IDLE;
      ret_reg <= FUM_IDLE;
      cfg_reg <= '0;
      szi_reg <= 2'h0;
      sent_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      ret_reg <= ret_next;
      cfg_reg <= cfg_next;
      szi_reg <= szi_next;
      sent_reg <= sent_next;
    end
  end

  // ==========================================================
  // indicators: one lamp walks on success, lamp 0 alone on error
  logic [3:0] led_reg, led_next;
  logic [31:0] led_cnt_reg, led_cnt_next;
  fum_status_t stat_reg, stat_next;

  always_comb begin
    led_next = `FUM_LED_OFF;
    led_cnt_next = 32'h0;
    stat_next.busy = active;
    stat_next.done = (st_reg == FUM_DONE);
    stat_next.error = (st_reg == FUM_ERROR);
    if (st_reg == FUM_ERROR) begin
      led_next = `FUM_LED_ERROR;
    end else if (st_reg == FUM_DONE) begin
      led_next = (led_reg == `FUM_LED_OFF) ? `FUM_LED_FIRST : led_reg;
      led_cnt_next = led_cnt_reg + 32'h1;
      if (led_cnt_reg == 32'(LED_STEP_CYC - 1)) begin
        led_cnt_next = 32'h0;
        led_next = {led_reg[2:0], led_reg[3]};
      end
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      led_reg <= `FUM_LED_OFF;
      led_cnt_reg <= 32'h0;
      stat_reg <= '0;
    end else begin
      led_reg <= led_next;
      led_cnt_reg <= led_cnt_next;
      stat_reg <= stat_next;
    end
  end

  assign indicator_out = led_reg;
  assign status_out = stat_reg;

endmodule : fum_master

// ---- verification/fum_master_assertions.sv ----
// port-level checker for the flash update uart master
// assumes the core parameters are handed on by the bind at the foot
`timescale 1ns/100ps
module fum_master_assertions import fum_pkg::*; #(
  parameter int BIT_CYC = 800,
  parameter int LED_STEP_CYC = 6250000,
  parameter bit BIG_ENDIAN = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic arst_n_in,
  // switch and link
  input wire logic start_switch_n_in,
  input wire logic serial_rx_in,
  input wire logic serial_tx_out,
  // setup and data source
  input wire fum_cfg_t cfg_in,
  input wire logic [7:0] data_in,
  input wire logic data_valid_in,
  input wire logic data_ready_out,
  // indicators and status
  input wire logic [3:0] indicator_out,
  input wire fum_status_t status_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);

  // ==========================================================
  // run length of the tx level; saturates so long idles stay legal
  logic tx_prev_reg;
  logic tx_prev_next;
  logic [15:0] run_reg;
  logic [15:0] run_next;
  always_comb begin
    tx_prev_next = serial_tx_out;
    if (serial_tx_out != tx_prev_reg) begin
      run_next = 16'h0001;
    end else if (run_reg != 16'hFFFF) begin
      run_next = run_reg + 16'h0001;
    end else begin
      run_next = run_reg;
    end
  end
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_prev_reg <= 1'b1;
      run_reg <= 16'hFFFF;
    end else begin
      tx_prev_reg <= tx_prev_next;
      run_reg <= run_next;
    end
  end

  // ==========================================================
  // properties
  sequence s_take;
    data_valid_in && data_ready_out;
  endsequence
  sequence s_start_bit;
    !serial_tx_out && status_out.busy;
  endsequence
  property p_low_run;
    $rose(serial_tx_out) |->
      (run_reg % BIT_CYC == 0) && (run_reg <= 9 * BIT_CYC);
  endproperty
  property p_stop_len;
    $fell(serial_tx_out) |-> run_reg >= BIT_CYC;
  endproperty
  property p_idle_high;
    !status_out.busy |-> serial_tx_out;
  endproperty
  property p_take_frame;
    s_take |=> s_start_bit;
  endproperty
  property p_ready_pulse;
    s_take |=> !data_ready_out;
  endproperty
  property p_ready_busy;
    data_ready_out |-> status_out.busy && !status_out.error;
  endproperty
  property p_err_hold;
    status_out.error |=> status_out.error && indicator_out == 4'h1;
  endproperty
  property p_err_show;
    $rose(status_out.error) |-> indicator_out == 4'h1 && !status_out.done;
  endproperty
  property p_done_walk;
    status_out.done && $past(status_out.done) &&
      indicator_out != $past(indicator_out) |->
      indicator_out == {$past(indicator_out[2:0]), $past(indicator_out[3])};
  endproperty
  property p_done_onehot;
    status_out.done |-> $onehot(indicator_out);
  endproperty

  a_low_run: assert property (p_low_run)
    else $error("tx low run not whole bit times");
  a_stop_len: assert property (p_stop_len)
    else $error("tx high run shorter than one bit");
  a_idle_high: assert property (p_idle_high)
    else $error("tx active while not busy");
  a_take_frame: assert property (p_take_frame)
    else $error("no start bit after byte taken");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held after byte taken");
  a_ready_busy: assert property (p_ready_busy)
    else $error("ready outside a session");
  a_err_hold: assert property (p_err_hold)
    else $error("error state left before reset");
  a_err_show: assert property (p_err_show)
    else $error("wrong error pattern");
  a_done_walk: assert property (p_done_walk)
    else $error("done indicators not walking");
  a_done_onehot: assert property (p_done_onehot)
    else $error("done indicators not one lamp");
endmodule : fum_master_assertions

bind fum_master fum_master_assertions #(
  .BIT_CYC(BIT_CYC),
  .LED_STEP_CYC(LED_STEP_CYC),
  .BIG_ENDIAN(BIG_ENDIAN)
) fum_master_assertions_i (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in),
  .start_switch_n_in(start_switch_n_in), .serial_rx_in(serial_rx_in),
  .serial_tx_out(serial_tx_out), .cfg_in(cfg_in), .data_in(data_in),
  .data_valid_in(data_valid_in), .data_ready_out(data_ready_out),
  .indicator_out(indicator_out), .status_out(status_out)
);

// ---- verification/fum_slave_model.sv ----
// behavioural reprogramming slave on the far side of the link
// assumes 8n1 framing at BIT_CYC clocks a bit; it drives its tx line high when idle
`timescale 1ns/100ps
module fum_slave_model #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic mclk_in,
  // link seen from the slave
  input wire logic serial_in,
  output logic serial_out,
  // behaviour controls
  input wire logic slow_in,
  input wire logic bad_stop_in,
  input wire logic extra_in
);
  logic [7:0] got[$];
  logic [7:0] b;
  logic pending;
  int frame_errs;
  int early_starts;

  // answer after start, after erase+index, after write+size, each unit
  function automatic bit group_end(input int count);
    return count == 1 || count == 3 || count == 8 ||
      (count > 8 && (count - 8) % 256 == 0);
  endfunction

  task automatic send_ready();
    logic [9:0] frame;
    frame = {~bad_stop_in, 8'h55, 1'b0};
    repeat (slow_in ? 5 * BIT_CYC : BIT_CYC) @(posedge mclk_in);
    for (int i = 0; i < 10; i++) begin
      serial_out <= frame[i];
      repeat (BIT_CYC) @(posedge mclk_in);
    end
    serial_out <= 1'b1; // line driven high again as idle
  endtask

  initial begin
    serial_out = 1'b1;
    pending = 1'b0;
    frame_errs = 0;
    early_starts = 0;
    forever begin
      @(negedge serial_in);
      repeat (BIT_CYC / 2) @(posedge mclk_in);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge mclk_in);
        b[i] = serial_in;
      end
      repeat (BIT_CYC) @(posedge mclk_in);
      if (serial_in !== 1'b1) frame_errs++;
      got.push_back(b);
      if (group_end(got.size())) begin
        pending = 1'b1;
        send_ready();
        // stray codes while the master stalls for data force an overrun
        if (extra_in && got.size() == 8) repeat (2) send_ready();
        pending = 1'b0;
      end
    end
  end

  // a start bit before our ready code breaks the handshake
  always @(negedge serial_in) begin
    if (pending) early_starts++;
  end
endmodule : fum_slave_model

// ---- verification/fum_master_tb.sv ----
// self-checking bench for the flash update uart master
// assumes fum_slave_model on the link and shortened bit and lamp times
`timescale 1ns/100ps
module fum_master_tb import fum_pkg::*;;
  localparam int BIT = 8;
  localparam int LED = 16;
  logic mclk_in;
  logic arst_n_in;
  logic start_switch_n_in;
  logic serial_rx_in;
  logic serial_tx_out;
  fum_cfg_t cfg_in;
  logic [7:0] data_in;
  logic data_valid_in;
  logic data_ready_out;
  logic [3:0] indicator_out;
  fum_status_t status_out;
  logic slow;
  logic bad_stop;
  logic extra;
  logic took;
  logic [7:0] src[$];
  int n_taken;
  int mismatches;
  int n_compared;
  int cycles;

  fum_master #(.BIT_CYC(BIT), .LED_STEP_CYC(LED), .BIG_ENDIAN(1'b0))
  fum_master_i (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .start_switch_n_in(start_switch_n_in), .serial_rx_in(serial_rx_in),
    .serial_tx_out(serial_tx_out), .cfg_in(cfg_in), .data_in(data_in),
    .data_valid_in(data_valid_in), .data_ready_out(data_ready_out),
    .indicator_out(indicator_out), .status_out(status_out)
  );
  fum_slave_model #(.BIT_CYC(BIT)) fum_slave_model_i (
    .mclk_in(mclk_in), .serial_in(serial_tx_out),
    .serial_out(serial_rx_in), .slow_in(slow), .bad_stop_in(bad_stop),
    .extra_in(extra)
  );

  // ==========================================================
  // clock, data source and hang guard
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in) took <= data_valid_in && data_ready_out;
  // source holds each byte until taken, then drops valid for a cycle
  always @(negedge mclk_in) begin
    if (took) begin
      n_taken++;
      data_valid_in = 1'b0;
    end else if (!data_valid_in && n_taken < src.size()) begin
      data_in = src[n_taken];
      data_valid_in = 1'b1;
    end
  end
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 90000) begin
      mismatches++;
      summarize();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset();
    @(negedge mclk_in);
    arst_n_in = 1'b0;
    fum_slave_model_i.got.delete();
    n_taken = 0;
    repeat (6) @(negedge mclk_in);
    chk("tx in reset", 32'h1, serial_tx_out);
    chk("status in reset", 32'h0, status_out);
    chk("indicators in reset", 32'h0, indicator_out);
    chk("ready in reset", 32'h0, data_ready_out);
    arst_n_in = 1'b1;
    repeat (20) @(negedge mclk_in);
    chk("bytes before press", 32'h0, fum_slave_model_i.got.size());
  endtask

  task automatic press(input logic [7:0] idx, input logic [31:0] size);
    cfg_in.block_index = idx;
    cfg_in.prog_size = size;
    start_switch_n_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    start_switch_n_in = 1'b1;
  endtask

  task automatic wait_end(input int limit);
    int k;
    k = 0;
    while (status_out.done !== 1'b1 && status_out.error !== 1'b1 &&
           k < limit) begin
      @(negedge mclk_in);
      k++;
    end
    if (k >= limit) begin
      mismatches++;
      $display("BAD wait_end expected end seen timeout after %0d", k);
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic t_bad_setup();
    logic [39:0] bad[4];
    bad = '{{8'h26, 32'h1}, {8'h00, 32'h0}, {8'h1E, 32'h1001},
            {8'h00, 32'h2001}};
    foreach (bad[i]) begin
      do_reset();
      press(bad[i][39:32], bad[i][31:0]);
      wait_end(200);
      chk("error on bad setup", 32'h1, status_out.error);
      chk("bytes on bad setup", 32'h0, fum_slave_model_i.got.size());
    end
  endtask

  task automatic t_frame_error();
    do_reset();
    slow = 1'b0;
    bad_stop = 1'b1;
    press(8'h25, 32'h1000);
    wait_end(2000);
    chk("error after bad stop", 32'h1, status_out.error);
    chk("error indicators", 32'h1, indicator_out);
    bad_stop = 1'b0;
    press(8'h25, 32'h1000);
    repeat (16 * BIT) @(negedge mclk_in);
    chk("bytes after error", 32'h1, fum_slave_model_i.got.size());
    chk("error held", 32'h1, status_out.error);
  endtask

  task automatic t_overrun();
    do_reset();
    src.delete();
    extra = 1'b1;
    press(8'h1D, 32'h3);
    wait_end(3000);
    extra = 1'b0;
    chk("error after overrun", 32'h1, status_out.error);
    chk("overrun indicators", 32'h1, indicator_out);
    chk("bytes before overrun", 32'h8, fum_slave_model_i.got.size());
  endtask

  task automatic t_full_run();
    logic [7:0] exp[$];
    do_reset();
    src.delete();
    for (int i = 0; i < 259; i++) src.push_back(8'(i * 7));
    slow = 1'b1;
    press(8'h1D, 32'h103);
    wait_end(60000);
    exp = '{8'h10, 8'h11, 8'h1D, 8'h12, 8'h03, 8'h01, 8'h00, 8'h00};
    exp = {exp, src};
    while (exp.size() < 520) exp.push_back(8'hFF);
    chk("byte count", 32'd520, fum_slave_model_i.got.size());
    foreach (exp[i]) chk("sent byte", exp[i], fum_slave_model_i.got[i]);
    chk("bytes taken", 32'h103, n_taken);
    chk("done", 32'h1, status_out.done);
    chk("early starts", 32'h0, fum_slave_model_i.early_starts);
    chk("slave frame errors", 32'h0, fum_slave_model_i.frame_errs);
    repeat (LED / 2) @(negedge mclk_in);
    for (int i = 0; i < 5; i++) begin
      chk("done indicators", 32'h1 << (i % 4), indicator_out);
      repeat (LED) @(negedge mclk_in);
    end
    // a press while done opens a fresh session
    press(8'h1D, 32'h3);
    repeat (16 * BIT) @(negedge mclk_in);
    chk("restart byte", 32'h10, fum_slave_model_i.got[520]);
    chk("busy after restart", 32'h1, status_out.busy);
  endtask

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize

  initial begin
    mclk_in = 1'b0;
    arst_n_in = 1'b0;
    start_switch_n_in = 1'b1;
    cfg_in = '0;
    data_in = 8'h00;
    data_valid_in = 1'b0;
    slow = 1'b0;
    bad_stop = 1'b0;
    extra = 1'b0;
    took = 1'b0;
    mismatches = 0;
    n_compared = 0;
    cycles = 0;
    n_taken = 0;
    t_bad_setup();
    t_frame_error();
    t_overrun();
    t_full_run();
    summarize();
  end
endmodule : fum_master_tb
